// >>> pioc_defs.vh
/*
 * Constants of the parallel I/O port block: register addresses, special
 * bit positions and reset values.
 * Assumes inclusion by its bare name from the port block design files.
 */
`ifndef PIOC_DEFS_VH
`define PIOC_DEFS_VH

// ------------------------------------------------------------
// Register addresses, three per port
// ------------------------------------------------------------
`define PIOC_OFS_DATA 2'h0
`define PIOC_OFS_CFG 2'h1
`define PIOC_OFS_PIN 2'h2
`define PIOC_BASE_A 6'h00
`define PIOC_BASE_B 6'h01
`define PIOC_BASE_G 6'h02
`define PIOC_BASE_H 6'h03
`define PIOC_BASE_L 6'h04

// ------------------------------------------------------------
// Special port bit positions
// ------------------------------------------------------------
`define PIOC_G_IRQ_BIT 0
`define PIOC_G_WDOG_BIT 1
`define PIOC_G_T1CAP_BIT 2
`define PIOC_G_T1IO_BIT 3
`define PIOC_G_SO_BIT 4
`define PIOC_G_SK_BIT 5
`define PIOC_G_SI_BIT 6
`define PIOC_G_CLKOUT_BIT 7
`define PIOC_G_IDLE_BIT 6
`define PIOC_G_HALT_BIT 7
`define PIOC_G_ALTSK_BIT 6
`define PIOC_G_RC_STARTUP_DELAY_ENABLE_BIT 7

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define PIOC_RST_CFG 8'h00
`define PIOC_RST_DATA 8'h00
`define PIOC_RST_PIN 8'h00
`define PIOC_RDATA_NONE 8'h00

`endif

// >>> pioc_port_cell.v
/*
 * One 8-bit general purpose port: configuration and output data latches,
 * pin level capture and per-bit pad control.
 * Assumes register strobes come from the owning block's address decode and
 * that pad inputs are synchronous to sys_clk.
 */
`timescale 1ns/10ps
`include "pioc_defs.vh"

module pioc_port_cell (
    input wire sys_clk,
    input wire rst,
    input wire wr_cfg,
    input wire wr_data,
    input wire [7:0] wdata,
    input wire [7:0] pad_in,
    output reg [7:0] cfg,
    output reg [7:0] data,
    output reg [7:0] level,
    output wire [7:0] pad_out,
    output wire [7:0] pad_oe,
    output wire [7:0] pad_pull_en
);

    // ------------------------------------------------------------
    // Latches
    // ------------------------------------------------------------
    // Reset to hi-z
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cfg <= `PIOC_RST_CFG;
            data <= `PIOC_RST_DATA;
            level <= `PIOC_RST_PIN;
        end else begin
            if (wr_cfg) begin
                cfg <= wdata;
            end
            if (wr_data) begin
                data <= wdata;
            end
            level <= pad_in;
        end
    end

    // ------------------------------------------------------------
    // Pad control
    // ------------------------------------------------------------
    // Mode from config/data pair
    assign pad_oe = cfg;
    assign pad_out = data;
    assign pad_pull_en = ~cfg & data;

endmodule // pioc_port_cell

// >>> pioc_parallel_io.v
/*
 * Parallel I/O ports A, B, G, H and L with their register file on the core
 * data memory bus, special port G controls and alternate pin routing.
 * Assumes a single-cycle read/write strobe bus synchronous to sys_clk,
 * pad inputs synchronous to sys_clk, and external pad logic resolving
 * the out/oe/pull signals into pin levels.
 */
`timescale 1ns/10ps
`include "pioc_defs.vh"

module pioc_parallel_io #(
    parameter [7:0] A_BONDED_MASK = 8'hFF
) (
    input wire sys_clk,
    input wire rst,
    input wire [7:0] mem_addr,
    input wire mem_wr,
    input wire mem_rd,
    input wire [7:0] mem_wdata,
    output reg [7:0] mem_rdata,
    input wire watchdog_select,
    input wire watchdog_level,
    input wire osc_clock_in,
    input wire [7:0] analog_sel_a,
    input wire [7:0] analog_sel_b,
    input wire [7:0] a_pad_in,
    output wire [7:0] a_pad_out,
    output wire [7:0] a_pad_oe,
    output wire [7:0] a_pad_pull_en,
    input wire [7:0] b_pad_in,
    output wire [7:0] b_pad_out,
    output wire [7:0] b_pad_oe,
    output wire [7:0] b_pad_pull_en,
    input wire [7:0] g_pad_in,
    output wire [7:0] g_pad_out,
    output wire [7:0] g_pad_oe,
    output wire [7:0] g_pad_pull_en,
    input wire [7:0] h_pad_in,
    output wire [7:0] h_pad_out,
    output wire [7:0] h_pad_oe,
    output wire [7:0] h_pad_pull_en,
    input wire [7:0] l_pad_in,
    output wire [7:0] l_pad_out,
    output wire [7:0] l_pad_oe,
    output wire [7:0] l_pad_pull_en,
    output reg halt_request,
    output reg idle_request,
    output wire alt_shift_clock_phase,
    output wire rc_startup_delay_enable,
    output wire external_irq_in,
    output wire timer1_capture_in,
    output wire timer1_io_pin,
    output wire serial_data_in,
    output wire serial_shift_clock,
    output wire timer2_input_a,
    output wire timer2_input_b,
    output wire usart_receive_in,
    output wire usart_ext_clock,
    output wire [7:0] wakeup_levels,
    output wire [15:0] analog_channel_sel
);

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    function hit;
        input [7:0] addr;
        input [5:0] base;
        input [1:0] ofs;
        begin
            hit = (addr == {base, ofs});
        end
    endfunction

    // Masked bits read zero; undefined values are allowed there
    function [7:0] masked;
        input [7:0] value;
        input [7:0] keep;
        begin
            masked = value & keep;
        end
    endfunction

    wire [7:0] a_cfg;
    wire [7:0] a_data;
    wire [7:0] a_level;
    wire [7:0] b_cfg;
    wire [7:0] b_data;
    wire [7:0] b_level;
    wire [7:0] g_cfg;
    wire [7:0] g_data;
    wire [7:0] g_level;
    wire [7:0] h_cfg;
    wire [7:0] h_data;
    wire [7:0] h_level;
    wire [7:0] l_cfg;
    wire [7:0] l_data;
    wire [7:0] l_level;
    wire [7:0] g_cell_out;
    wire [7:0] g_cell_oe;
    wire [7:0] g_cell_pull;
    wire wr_g_data;
    wire wr_a_cfg;
    wire wr_a_data;
    wire wr_b_cfg;
    wire wr_b_data;
    wire wr_g_cfg;
    wire wr_h_cfg;
    wire wr_h_data;
    wire wr_l_cfg;
    wire wr_l_data;

    // ------------------------------------------------------------
    // Write strobes, one per latch
    // ------------------------------------------------------------
    // Pin registers get no strobe, so writes to them are dropped
    assign wr_a_cfg = mem_wr & hit(mem_addr, `PIOC_BASE_A, `PIOC_OFS_CFG);
    assign wr_a_data = mem_wr & hit(mem_addr, `PIOC_BASE_A, `PIOC_OFS_DATA);
    assign wr_b_cfg = mem_wr & hit(mem_addr, `PIOC_BASE_B, `PIOC_OFS_CFG);
    assign wr_b_data = mem_wr & hit(mem_addr, `PIOC_BASE_B, `PIOC_OFS_DATA);
    assign wr_g_cfg = mem_wr & hit(mem_addr, `PIOC_BASE_G, `PIOC_OFS_CFG);
    assign wr_g_data = mem_wr & hit(mem_addr, `PIOC_BASE_G, `PIOC_OFS_DATA);
    assign wr_h_cfg = mem_wr & hit(mem_addr, `PIOC_BASE_H, `PIOC_OFS_CFG);
    assign wr_h_data = mem_wr & hit(mem_addr, `PIOC_BASE_H, `PIOC_OFS_DATA);
    assign wr_l_cfg = mem_wr & hit(mem_addr, `PIOC_BASE_L, `PIOC_OFS_CFG);
    assign wr_l_data = mem_wr & hit(mem_addr, `PIOC_BASE_L, `PIOC_OFS_DATA);

    // ------------------------------------------------------------
    // Port instances
    // ------------------------------------------------------------
    // Three registers per port
    pioc_port_cell u_port_a (
        .sys_clk(sys_clk),
        .rst(rst),
        .wr_cfg(wr_a_cfg),
        .wr_data(wr_a_data),
        .wdata(mem_wdata),
        .pad_in(a_pad_in),
        .cfg(a_cfg),
        .data(a_data),
        .level(a_level),
        .pad_out(a_pad_out),
        .pad_oe(a_pad_oe),
        .pad_pull_en(a_pad_pull_en)
    );

    pioc_port_cell u_port_b (
        .sys_clk(sys_clk),
        .rst(rst),
        .wr_cfg(wr_b_cfg),
        .wr_data(wr_b_data),
        .wdata(mem_wdata),
        .pad_in(b_pad_in),
        .cfg(b_cfg),
        .data(b_data),
        .level(b_level),
        .pad_out(b_pad_out),
        .pad_oe(b_pad_oe),
        .pad_pull_en(b_pad_pull_en)
    );

    pioc_port_cell u_port_g (
        .sys_clk(sys_clk),
        .rst(rst),
        .wr_cfg(wr_g_cfg),
        .wr_data(wr_g_data),
        .wdata(mem_wdata),
        .pad_in(g_pad_in),
        .cfg(g_cfg),
        .data(g_data),
        .level(g_level),
        .pad_out(g_cell_out),
        .pad_oe(g_cell_oe),
        .pad_pull_en(g_cell_pull)
    );

    pioc_port_cell u_port_h (
        .sys_clk(sys_clk),
        .rst(rst),
        .wr_cfg(wr_h_cfg),
        .wr_data(wr_h_data),
        .wdata(mem_wdata),
        .pad_in(h_pad_in),
        .cfg(h_cfg),
        .data(h_data),
        .level(h_level),
        .pad_out(h_pad_out),
        .pad_oe(h_pad_oe),
        .pad_pull_en(h_pad_pull_en)
    );

    pioc_port_cell u_port_l (
        .sys_clk(sys_clk),
        .rst(rst),
        .wr_cfg(wr_l_cfg),
        .wr_data(wr_l_data),
        .wdata(mem_wdata),
        .pad_in(l_pad_in),
        .cfg(l_cfg),
        .data(l_data),
        .level(l_level),
        .pad_out(l_pad_out),
        .pad_oe(l_pad_oe),
        .pad_pull_en(l_pad_pull_en)
    );

    // ------------------------------------------------------------
    // Special port pad overrides
    // ------------------------------------------------------------
    // Bit 7 carries oscillator clock
    assign g_pad_out[7] = osc_clock_in;
    assign g_pad_oe[7] = 1'b1;
    assign g_pad_pull_en[7] = 1'b0;
    assign g_pad_out[6] = 1'b0;
    assign g_pad_oe[6] = 1'b0;
    assign g_pad_pull_en[6] = 1'b0;
    assign g_pad_out[5:2] = g_cell_out[5:2];
    assign g_pad_oe[5:2] = g_cell_oe[5:2];
    assign g_pad_pull_en[5:2] = g_cell_pull[5:2];
    // Watchdog output, pulled up, sinks when active
    assign g_pad_out[1] = watchdog_select ? 1'b0 : g_cell_out[1];
    assign g_pad_oe[1] = watchdog_select ? ~watchdog_level : g_cell_oe[1];
    assign g_pad_pull_en[1] = watchdog_select ? 1'b1 : g_cell_pull[1];
    assign g_pad_out[0] = g_cell_out[0];
    assign g_pad_oe[0] = g_cell_oe[0];
    assign g_pad_pull_en[0] = g_cell_pull[0];

    // ------------------------------------------------------------
    // Special controls
    // ------------------------------------------------------------
    // Alternate shift clock phase
    assign alt_shift_clock_phase = g_cfg[`PIOC_G_ALTSK_BIT];
    assign rc_startup_delay_enable = g_cfg[`PIOC_G_RC_STARTUP_DELAY_ENABLE_BIT];

    // One-cycle requests; the power controller holds the mode itself
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            halt_request <= 1'b0;
            idle_request <= 1'b0;
        end else begin
            halt_request <= wr_g_data & mem_wdata[`PIOC_G_HALT_BIT];
            idle_request <= wr_g_data & mem_wdata[`PIOC_G_IDLE_BIT];
        end
    end

    // ------------------------------------------------------------
    // Alternate functions
    // ------------------------------------------------------------
    // Special port G and port L alternates
    assign external_irq_in = g_level[`PIOC_G_IRQ_BIT];
    assign timer1_capture_in = g_level[`PIOC_G_T1CAP_BIT];
    assign timer1_io_pin = g_level[`PIOC_G_T1IO_BIT];
    assign serial_shift_clock = g_level[`PIOC_G_SK_BIT];
    assign serial_data_in = g_level[`PIOC_G_SI_BIT];
    assign wakeup_levels = l_level;
    assign timer2_input_b = l_level[5];
    assign timer2_input_a = l_level[4];
    assign usart_receive_in = l_level[3];
    assign usart_ext_clock = l_level[1];
    // Channels 0-7 on A, 8-15 on B
    assign analog_channel_sel = {analog_sel_b, analog_sel_a};

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    reg [7:0] next_rdata;

    always @* begin
        next_rdata = `PIOC_RDATA_NONE;
        case (mem_addr)
            {`PIOC_BASE_A, `PIOC_OFS_DATA}: next_rdata = a_data;
            {`PIOC_BASE_A, `PIOC_OFS_CFG}: next_rdata = a_cfg;
            {`PIOC_BASE_A, `PIOC_OFS_PIN}: next_rdata = masked(a_level, A_BONDED_MASK & ~analog_sel_a);
            {`PIOC_BASE_B, `PIOC_OFS_DATA}: next_rdata = b_data;
            {`PIOC_BASE_B, `PIOC_OFS_CFG}: next_rdata = b_cfg;
            {`PIOC_BASE_B, `PIOC_OFS_PIN}: next_rdata = masked(b_level, ~analog_sel_b);
            {`PIOC_BASE_G, `PIOC_OFS_DATA}: next_rdata = masked(g_data, 8'h3F);
            {`PIOC_BASE_G, `PIOC_OFS_CFG}: next_rdata = g_cfg;
            {`PIOC_BASE_G, `PIOC_OFS_PIN}: next_rdata = g_level;
            {`PIOC_BASE_H, `PIOC_OFS_DATA}: next_rdata = h_data;
            {`PIOC_BASE_H, `PIOC_OFS_CFG}: next_rdata = h_cfg;
            {`PIOC_BASE_H, `PIOC_OFS_PIN}: next_rdata = h_level;
            {`PIOC_BASE_L, `PIOC_OFS_DATA}: next_rdata = l_data;
            {`PIOC_BASE_L, `PIOC_OFS_CFG}: next_rdata = l_cfg;
            {`PIOC_BASE_L, `PIOC_OFS_PIN}: next_rdata = l_level;
            default: next_rdata = `PIOC_RDATA_NONE;
        endcase
    end

    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            mem_rdata <= `PIOC_RDATA_NONE;
        end else if (mem_rd) begin
            mem_rdata <= next_rdata;
        end
    end

endmodule // pioc_parallel_io

// >>> pioc_board_pins.sv
/*
 * Board circuitry at one 8-bit port: resolves the block's drive, enable
 * and pull-up outputs plus an external driver into pin levels.
 * Assumes the bench never drives a pin that the block also drives.
 */
`timescale 1ns/10ps

module pioc_board_pins (
    input wire sys_clk,
    input wire [7:0] pad_out,
    input wire [7:0] pad_oe,
    input wire [7:0] pad_pull_en,
    input wire [7:0] ext_en,
    input wire [7:0] ext_val,
    output wire [7:0] pad_in
);
    // Floating pins flip every cycle so no stale value passes for a level
    logic [7:0] last = 8'h00;

    always @(posedge sys_clk) begin
        last <= pad_in;
    end

    assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_val) | (~pad_oe & ~ext_en & pad_pull_en)
        | (~pad_oe & ~ext_en & ~pad_pull_en & ~last);
endmodule // pioc_board_pins

// >>> pioc_parallel_io_sva.sv
/*
 * Checker for the parallel I/O port block, bound to its top module.
 * Assumes the single sys_clk domain and the register map of the defines.
 */
`timescale 1ns/10ps

module pioc_parallel_io_sva (
    input wire sys_clk,
    input wire rst,
    input wire [7:0] mem_addr,
    input wire mem_wr,
    input wire mem_rd,
    input wire [7:0] mem_wdata,
    input wire [7:0] mem_rdata,
    input wire watchdog_select,
    input wire watchdog_level,
    input wire osc_clock_in,
    input wire [7:0] l_pad_in,
    input wire [7:0] l_pad_oe,
    input wire [7:0] g_pad_out,
    input wire [7:0] g_pad_oe,
    input wire [7:0] g_pad_pull_en,
    input wire [7:0] h_pad_out,
    input wire [7:0] h_pad_oe,
    input wire [7:0] h_pad_pull_en,
    input wire halt_request,
    input wire idle_request,
    input wire alt_shift_clock_phase,
    input wire rc_startup_delay_enable
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);

    mode_pull_a: assert property (h_pad_pull_en == (~h_pad_oe & h_pad_out))
        else $error("pull enable differs from cfg0 data1");
    cfg_write_a: assert property (mem_wr && mem_addr == 8'h11 |=> l_pad_oe == $past(mem_wdata))
        else $error("port L enables differ from written config");
    g6_input_a: assert property (!g_pad_oe[6] && !g_pad_pull_en[6])
        else $error("input only pin driven or pulled");
    wdog_pin_a: assert property (watchdog_select |-> g_pad_pull_en[1] && !g_pad_out[1]
        && g_pad_oe[1] == !watchdog_level)
        else $error("watchdog pin setup wrong");
    g7_clock_a: assert property (g_pad_oe[7] && g_pad_out[7] == osc_clock_in)
        else $error("clock out pin not following oscillator");
    g_rdata_a: assert property (mem_rd && mem_addr == 8'h08 |=> mem_rdata[7:6] == 2'h0)
        else $error("special data bits 7 and 6 read nonzero");
    halt_pulse_a: assert property (mem_wr && mem_addr == 8'h08 && mem_wdata[7] |=> halt_request)
        else $error("halt request missing after write");
    idle_pulse_a: assert property (mem_wr && mem_addr == 8'h08 |=> idle_request == $past(mem_wdata[6]))
        else $error("idle request differs from written bit");
    alt_phase_a: assert property (mem_wr && mem_addr == 8'h09 |=> alt_shift_clock_phase == $past(mem_wdata[6])
        && rc_startup_delay_enable == $past(mem_wdata[7]))
        else $error("special config controls differ from write");
    pin_read_a: assert property (mem_rd && mem_addr == 8'h12 |=> mem_rdata == $past(l_pad_in, 2))
        else $error("pin read differs from captured level");
endmodule // pioc_parallel_io_sva

bind pioc_parallel_io pioc_parallel_io_sva u_pioc_parallel_io_sva (.sys_clk, .rst, .mem_addr, .mem_wr, .mem_rd,
    .mem_wdata, .mem_rdata, .watchdog_select, .watchdog_level, .osc_clock_in, .l_pad_in, .l_pad_oe, .g_pad_out,
    .g_pad_oe, .g_pad_pull_en, .h_pad_out, .h_pad_oe, .h_pad_pull_en, .halt_request, .idle_request,
    .alt_shift_clock_phase, .rc_startup_delay_enable);

// >>> pioc_parallel_io_bench.sv
/*
 * Self-checking bench for the parallel I/O port block.
 * Assumes board models on ports G and L; ports A, B and H driven directly.
 */
`timescale 1ns/10ps

module pioc_parallel_io_bench;
    logic sys_clk = 1'h0;
    logic rst = 1'h1;
    logic mem_wr = 1'h0, mem_rd = 1'h0, watchdog_select = 1'h0, watchdog_level = 1'h1, osc_clock_in = 1'h0;
    logic [7:0] mem_addr = 8'h00, mem_wdata = 8'h00, analog_sel_a = 8'h00, analog_sel_b = 8'h00;
    logic [7:0] a_pad_in = 8'h00, b_pad_in = 8'h00, h_pad_in = 8'h00;
    logic [7:0] g_ext_en = 8'h7D, g_ext_val = 8'h00, l_ext_en = 8'hC0, l_ext_val = 8'h80;
    wire [7:0] mem_rdata, g_pad_in, g_pad_out, g_pad_oe, g_pad_pull_en, l_pad_in, l_pad_out, l_pad_oe;
    wire [7:0] l_pad_pull_en, h_pad_out, h_pad_oe, h_pad_pull_en, a_pad_oe, wakeup_levels;
    wire [7:0] a_pad_out, a_pad_pull_en, b_pad_out, b_pad_oe, b_pad_pull_en;
    wire [15:0] analog_channel_sel;
    wire halt_request, idle_request, alt_shift_clock_phase, rc_startup_delay_enable, external_irq_in;
    wire timer1_capture_in, timer1_io_pin, serial_data_in, serial_shift_clock, timer2_input_a, timer2_input_b;
    wire usart_receive_in, usart_ext_clock;
    int n_mismatch = 0, checks_done = 0;

    always #12.5 sys_clk = ~sys_clk;

    pioc_parallel_io #(.A_BONDED_MASK(8'h7F)) u_pioc_parallel_io (.sys_clk, .rst, .mem_addr, .mem_wr, .mem_rd,
        .mem_wdata, .mem_rdata, .watchdog_select, .watchdog_level, .osc_clock_in, .analog_sel_a, .analog_sel_b,
        .a_pad_in, .a_pad_out, .a_pad_oe, .a_pad_pull_en, .b_pad_in, .b_pad_out, .b_pad_oe,
        .b_pad_pull_en, .g_pad_in, .g_pad_out, .g_pad_oe, .g_pad_pull_en, .h_pad_in, .h_pad_out, .h_pad_oe,
        .h_pad_pull_en, .l_pad_in, .l_pad_out, .l_pad_oe, .l_pad_pull_en, .halt_request, .idle_request,
        .alt_shift_clock_phase, .rc_startup_delay_enable, .external_irq_in, .timer1_capture_in, .timer1_io_pin,
        .serial_data_in, .serial_shift_clock, .timer2_input_a, .timer2_input_b, .usart_receive_in,
        .usart_ext_clock, .wakeup_levels, .analog_channel_sel);
    pioc_board_pins u_pioc_board_pins_g (.sys_clk, .pad_out(g_pad_out), .pad_oe(g_pad_oe),
        .pad_pull_en(g_pad_pull_en), .ext_en(g_ext_en), .ext_val(g_ext_val), .pad_in(g_pad_in));
    pioc_board_pins u_pioc_board_pins_l (.sys_clk, .pad_out(l_pad_out), .pad_oe(l_pad_oe),
        .pad_pull_en(l_pad_pull_en), .ext_en(l_ext_en), .ext_val(l_ext_val), .pad_in(l_pad_in));

    // ------------------------------------------------------------
    // Access tasks
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tick;
        @(posedge sys_clk);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        tick();
        mem_addr = a;
        mem_wdata = d;
        mem_wr = 1'h1;
        tick();
        mem_wr = 1'h0;
    endtask

    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        tick();
        mem_addr = a;
        mem_rd = 1'h1;
        tick();
        mem_rd = 1'h0;
        chk($sformatf("read %h", a), {8'h00, mem_rdata}, {8'h00, exp});
    endtask

    task automatic give_verdict;
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        repeat (20) @(posedge sys_clk);
        #1 rst = 1'h0;
        for (int p = 0; p < 5; p++) begin
            rdc(8'(p * 4), 8'h00);
            rdc(8'(p * 4 + 1), 8'h00);
        end
        chk("a oe", a_pad_oe, 8'h00);
        chk("a out pull", {a_pad_out, a_pad_pull_en}, 16'h0000);
        chk("b out oe", {b_pad_out, b_pad_oe}, 16'h0000);
        chk("b pull", b_pad_pull_en, 8'h00);
        wr(8'h04, 8'hF0);
        wr(8'h05, 8'h3C);
        chk("b oe", b_pad_oe, 8'h3C);
        chk("b drive", b_pad_out & b_pad_oe, 8'h30);
        chk("b pull set", b_pad_pull_en, 8'hC0);
        wr(8'h0C, 8'h0A);
        wr(8'h0D, 8'h0C);
        chk("h oe", h_pad_oe, 8'h0C);
        chk("h pull", h_pad_pull_en, 8'h02);
        chk("h drive", h_pad_out & h_pad_oe, 8'h08);
        rdc(8'h0C, 8'h0A);
        h_pad_in = 8'h5A;
        rdc(8'h0E, 8'h5A);
        wr(8'h0E, 8'hFF);
        rdc(8'h0D, 8'h0C);
        wr(8'h30, 8'hFF);
        rdc(8'h30, 8'h00);
        rdc(8'h13, 8'h00);
        wr(8'h10, 8'h35);
        wr(8'h11, 8'h0F);
        rdc(8'h12, 8'hB5);
        chk("wake", wakeup_levels, 8'hB5);
        chk("l alt", {timer2_input_b, timer2_input_a, usart_receive_in, usart_ext_clock}, 4'hC);
        a_pad_in = 8'hFF;
        b_pad_in = 8'hFF;
        analog_sel_a = 8'h0F;
        analog_sel_b = 8'hA5;
        rdc(8'h02, 8'h70);
        rdc(8'h06, 8'h5A);
        chk("chan", analog_channel_sel, 16'hA50F);
        for (int i = 0; i < 2; i++) begin
            g_ext_val = i[0] ? 8'hFF : 8'h00;
            tick();
            tick();
            chk("g alt", {external_irq_in, timer1_capture_in, timer1_io_pin, serial_shift_clock,
                serial_data_in}, {5{i[0]}});
        end
        // Board lets go of G before the block may drive it
        // G0-G7 device side free
        g_ext_en = 8'h00;
        wr(8'h08, 8'hC2);
        chk("halt idle", {halt_request, idle_request}, 2'h3);
        tick();
        chk("pulse end", {halt_request, idle_request}, 2'h0);
        wr(8'h09, 8'hC2);
        chk("alt phase", alt_shift_clock_phase, 1'h1);
        chk("start delay", rc_startup_delay_enable, 1'h1);
        chk("g oe", {g_pad_oe[7:6], g_pad_oe[1]}, 3'h5);
        rdc(8'h08, 8'h02);
        for (int i = 0; i < 2; i++) begin
            osc_clock_in = i[0];
            tick();
            chk("clk out", g_pad_out[7], i[0]);
        end
        watchdog_select = 1'h1;
        watchdog_level = 1'h0;
        tick();
        chk("wdog low", {g_pad_oe[1], g_pad_out[1], g_pad_pull_en[1]}, 3'h5);
        watchdog_level = 1'h1;
        tick();
        chk("wdog high", {g_pad_oe[1], g_pad_out[1], g_pad_pull_en[1]}, 3'h1);
        watchdog_select = 1'h0;
        tick();
        chk("g1 gpio", {g_pad_oe[1], g_pad_out[1], g_pad_pull_en[1]}, 3'h6);
        rst = 1'h1;
        tick();
        rst = 1'h0;
        chk("h oe rst", h_pad_oe, 8'h00);
        rdc(8'h0D, 8'h00);
        give_verdict();
    end

    // Tests need under a hundred cycles; four thousand means a hang
    initial begin
        #100000;
        n_mismatch++;
        give_verdict();
    end
endmodule // pioc_parallel_io_bench
